/* include/bit_decoder_defs.svh */
// constants for the serial port bit address decoder
`ifndef BIT_DECODER_DEFS_SVH
`define BIT_DECODER_DEFS_SVH
`define PORT_COUNT 4
`define BASE_WIDTH 6
`define SELECT_WIDTH 5
`define ADDR_WIDTH 12
`define AUX_DTR 5'h00
`define AUX_DSR 5'h01
`define AUX_RING 5'h02
`define AUX_LEVEL_LOW 5'h04
`define AUX_LEVEL_HIGH 5'h05
`define ACU_FIRST 5'h10
`define ACU_LAST 5'h17
`define ACU_LED 5'h1e
`endif

/* include/bit_decoder_pkg.sv */
// types for the serial port bit address decoder
package bit_decoder_pkg;
    typedef struct packed {
        logic [5:0] base;
        logic half;
        logic [4:0] select;
    } bit_addr_type;
    typedef struct packed {
        logic dtr;
        logic led;
    } aux_out_type;
endpackage : bit_decoder_pkg

/* core/bit_decoder.sv */
// bit address decoder for a four port serial expander
`timescale 1ns/10ps
`include "bit_decoder_defs.svh"

// Behaviour
// - each port owns 64 single bit addresses, controller first, aux last.
// - address lines A3 to A14 form the bit address being decoded.
// - lines A3 to A8 are compared with each port's six switches.
// - leftmost switch matches A3 as msb, rightmost matches A8 as lsb.
// - A9 low selects the controller half starting at bit 0.
// - A9 high selects the auxiliary half of modem and led bits.
// - A10 to A14 give the five select bits, A10 most significant.
// - unused auxiliary positions are reserved and have no effect.
// - port A auxiliary half also holds the autocall bits.
// - aux 0x20 to 0x22 read dtr, dsr, ring; writes to 0x20 drive dtr.
// - aux 0x24 reads low level switch and drives led; 0x25 high switch.
module bit_decoder #(
    parameter int PORTS = `PORT_COUNT
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic [`ADDR_WIDTH-1:0] bit_addr_in,
    input wire logic serial_bit_output_line_in,
    input wire logic write_strobe_in,
    input wire logic [PORTS*`BASE_WIDTH-1:0] base_switch_in,
    input wire logic [PORTS-1:0] dsr_in,
    input wire logic [PORTS-1:0] ring_indicator_signal_in,
    input wire logic [PORTS-1:0] level_low_in,
    input wire logic [PORTS-1:0] level_high_in,
    input wire logic [PORTS-1:0] ctrl_bit_in,
    input wire logic [7:0] acu_status_in,
    output logic serial_bit_input_line_out,
    output logic [PORTS-1:0] ctrl_sel_out,
    output logic [`SELECT_WIDTH-1:0] ctrl_select_out,
    output logic [PORTS-1:0] dtr_out,
    output logic [PORTS-1:0] led_out,
    output logic [7:0] acu_ctrl_out
);
    // ------------------------------------------------------------
    // address split
    // ------------------------------------------------------------
    bit_decoder_pkg::bit_addr_type addr;
    logic [PORTS-1:0] hit;
    logic [PORTS-1:0] ctrl_sel_d;
    logic [PORTS-1:0] aux_sel;
    logic read_d;

    assign addr = bit_decoder_pkg::bit_addr_type'(bit_addr_in);

    function automatic logic aux_is(input logic [4:0] sel,
                                    input logic [4:0] code);
        return sel == code;
    endfunction : aux_is

    // ------------------------------------------------------------
    // per port window match
    // ------------------------------------------------------------
    // bit order of bit_addr_in puts A3 at the top, so msb switch meets A3
    genvar g;
    generate
        for (g = 0; g < PORTS; g++) begin : g_port
            assign hit[g] = addr.base ==
                base_switch_in[g*`BASE_WIDTH +: `BASE_WIDTH];
            assign ctrl_sel_d[g] = hit[g] && !addr.half;
            assign aux_sel[g] = hit[g] && addr.half;
        end
    endgenerate

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    always_comb begin
        read_d = 1'b0;
        for (int p = 0; p < PORTS; p++) begin
            if (ctrl_sel_d[p]) begin
                read_d = ctrl_bit_in[p];
            end else if (aux_sel[p]) begin
                if (aux_is(addr.select, `AUX_DTR)) begin
                    read_d = dtr_out[p];
                end else if (aux_is(addr.select, `AUX_DSR)) begin
                    read_d = dsr_in[p];
                end else if (aux_is(addr.select, `AUX_RING)) begin
                    read_d = ring_indicator_signal_in[p];
                end else if (aux_is(addr.select, `AUX_LEVEL_LOW)) begin
                    read_d = level_low_in[p];
                end else if (aux_is(addr.select, `AUX_LEVEL_HIGH)) begin
                    read_d = level_high_in[p];
                end else if (p == 0 && addr.select >= `ACU_FIRST &&
                             addr.select <= `ACU_LAST) begin
                    read_d = acu_status_in[addr.select[2:0]];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    // one cycle of latency keeps every output straight off a flop
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            serial_bit_input_line_out <= 1'b0;
            ctrl_sel_out <= '0;
            ctrl_select_out <= '0;
        end else begin
            serial_bit_input_line_out <= read_d;
            ctrl_sel_out <= ctrl_sel_d;
            ctrl_select_out <= addr.select;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            dtr_out <= '0;
            led_out <= '0;
            acu_ctrl_out <= '0;
        end else if (write_strobe_in) begin
            for (int p = 0; p < PORTS; p++) begin
                if (aux_sel[p] && aux_is(addr.select, `AUX_DTR)) begin
                    dtr_out[p] <= serial_bit_output_line_in;
                end
                if (aux_sel[p] && aux_is(addr.select, `AUX_LEVEL_LOW)) begin
                    led_out[p] <= serial_bit_output_line_in;
                end
            end
            // other aux codes fall through untouched
            if (aux_sel[0] && addr.select >= `ACU_FIRST &&
                addr.select <= `ACU_LAST) begin
                acu_ctrl_out[addr.select[2:0]] <=
                    serial_bit_output_line_in;
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_nomatch_zero;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (hit == '0) |=> !serial_bit_input_line_out;
    endproperty
    a_nomatch_zero: assert property (p_nomatch_zero)
        else $error("unmatched read not zero");

    property p_ctrl_half;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (hit[0] && !addr.half) |=> ctrl_sel_out[0];
    endproperty
    a_ctrl_half: assert property (p_ctrl_half)
        else $error("controller not selected");

    property p_aux_half;
        @(posedge mclk_in) disable iff (!rst_n_in)
        addr.half |=> ctrl_sel_out == '0;
    endproperty
    a_aux_half: assert property (p_aux_half)
        else $error("controller selected in aux half");

    property p_select;
        @(posedge mclk_in) disable iff (!rst_n_in)
        1'b1 |=> ctrl_select_out == $past(bit_addr_in[4:0]);
    endproperty
    a_select: assert property (p_select)
        else $error("select bits wrong");

    property p_match;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (bit_addr_in[11:6] != base_switch_in[5:0]) |=> !ctrl_sel_out[0];
    endproperty
    a_match: assert property (p_match)
        else $error("port selected without match");

    property p_dtr_write;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (write_strobe_in && aux_sel[0] && addr.select == `AUX_DTR)
        |=> dtr_out[0] == $past(serial_bit_output_line_in);
    endproperty
    a_dtr_write: assert property (p_dtr_write)
        else $error("dtr not written");

    property p_led_write;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (write_strobe_in && aux_sel[0] && addr.select == `AUX_LEVEL_LOW)
        |=> led_out[0] == $past(serial_bit_output_line_in);
    endproperty
    a_led_write: assert property (p_led_write)
        else $error("led not written");

    property p_no_strobe;
        @(posedge mclk_in) disable iff (!rst_n_in)
        !write_strobe_in |=> $stable(dtr_out) && $stable(led_out);
    endproperty
    a_no_strobe: assert property (p_no_strobe)
        else $error("output changed without strobe");

    property p_reserved;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (aux_sel[1] && addr.select == 5'h03) |=> !serial_bit_input_line_out;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved bit read not zero");

    property p_acu_write;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (write_strobe_in && aux_sel[0] && addr.select == `ACU_FIRST)
        |=> acu_ctrl_out[0] == $past(serial_bit_output_line_in);
    endproperty
    a_acu_write: assert property (p_acu_write)
        else $error("autocall bit not written");

    property p_acu_hold;
        @(posedge mclk_in) disable iff (!rst_n_in)
        !write_strobe_in |=> $stable(acu_ctrl_out);
    endproperty
    a_acu_hold: assert property (p_acu_hold)
        else $error("autocall bits changed without strobe");

    // top port wins the read mux on every code it decodes, so an overlap cannot mask it
    property p_ring_read;
        @(posedge mclk_in) disable iff (!rst_n_in)
        (aux_sel[PORTS-1] && addr.select == `AUX_RING)
        |=> serial_bit_input_line_out ==
            $past(ring_indicator_signal_in[PORTS-1]);
    endproperty
    a_ring_read: assert property (p_ring_read)
        else $error("ring status not returned");

    c_ctrl: cover property (@(posedge mclk_in) ctrl_sel_out[0]);
    c_led: cover property (@(posedge mclk_in) $rose(led_out[0]));
    c_dtr: cover property (@(posedge mclk_in) $rose(dtr_out[3]));
    c_acu: cover property (@(posedge mclk_in) acu_ctrl_out != 8'h00);
endmodule : bit_decoder

/* tb/host_model.sv */
// host side model issuing single bit accesses
`timescale 1ns/10ps
module host_model (
    output logic [11:0] bit_addr_out,
    output logic data_out,
    output logic strobe_out
);
    initial begin
        bit_addr_out = 12'h000;
        data_out = 1'b0;
        strobe_out = 1'b0;
    end
    // op 0 sets zero, 1 sets one, 2 tests; caller drives at falling edge
    task automatic bit_op(input logic [11:0] a, input logic [1:0] op);
        bit_addr_out = a;
        data_out = op[0];
        strobe_out = (op != 2'h2);
    endtask : bit_op
endmodule : host_model

/* tb/serial_port_bit_address_decoder_test.sv */
// self-checking bench for the bit address decoder
`timescale 1ns/10ps
module serial_port_bit_address_decoder_test;
    logic mclk_in, rst_n_in, strobe, data, rd, e_rd;
    logic [11:0] addr;
    logic [23:0] base_sw;
    logic [3:0] dsr, ring, lvl_lo, lvl_hi, ctrl_bit, dtr, led, csel;
    logic [3:0] e_dtr, e_led, e_csel;
    logic [7:0] acu_st, acu, e_acu;
    logic [4:0] sel, e_sel;
    logic [31:0] lfsr_q;
    logic [11:0] rnd_a;
    int n_errors, checked;
    host_model i_host (.bit_addr_out(addr), .data_out(data),
        .strobe_out(strobe));
    bit_decoder i_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
        .bit_addr_in(addr), .serial_bit_output_line_in(data),
        .write_strobe_in(strobe), .base_switch_in(base_sw), .dsr_in(dsr),
        .ring_indicator_signal_in(ring), .level_low_in(lvl_lo),
        .level_high_in(lvl_hi), .ctrl_bit_in(ctrl_bit),
        .acu_status_in(acu_st), .serial_bit_input_line_out(rd),
        .ctrl_sel_out(csel), .ctrl_select_out(sel), .dtr_out(dtr),
        .led_out(led), .acu_ctrl_out(acu));
    initial begin
        mclk_in = 1'b0;
        forever #10 mclk_in = ~mclk_in;
    end
    function automatic logic [31:0] next_rnd(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : next_rnd
    // highest matching port wins when switch groups overlap
    function automatic int find_port(input logic [5:0] b);
        find_port = -1;
        for (int p = 0; p < 4; p++) begin
            if (base_sw[6*p +: 6] === b) find_port = p;
        end
    endfunction : find_port
    task automatic check_vec(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_vec
    task automatic check_bit(input logic got, input logic exp);
        check_vec({7'h00, got}, {7'h00, exp});
    endtask : check_bit
    // checks the previous access, then issues the next one
    task automatic step(input logic [11:0] a, input logic [1:0] op);
        int p;
        check_bit(rd, e_rd);
        check_vec({3'h0, sel}, {3'h0, e_sel});
        check_vec({4'h0, csel}, {4'h0, e_csel});
        check_vec({dtr, led}, {e_dtr, e_led});
        check_vec(acu, e_acu);
        lfsr_q = next_rnd(lfsr_q);
        {dsr, ring, lvl_lo, lvl_hi, ctrl_bit} = lfsr_q[19:0];
        acu_st = lfsr_q[27:20];
        p = find_port(a[11:6]);
        e_rd = 1'b0;
        e_csel = 4'h0;
        e_sel = a[4:0];
        if (p >= 0 && !a[5]) begin
            e_csel[p] = 1'b1;
            e_rd = ctrl_bit[p];
        end else if (p >= 0) begin
            case (a[4:0])
                5'h00: e_rd = e_dtr[p];
                5'h01: e_rd = dsr[p];
                5'h02: e_rd = ring[p];
                5'h04: e_rd = lvl_lo[p];
                5'h05: e_rd = lvl_hi[p];
                default: if (p == 0 && a[4:3] == 2'h2) e_rd = acu_st[a[2:0]];
            endcase
            if (op != 2'h2 && a[4:0] == 5'h00) e_dtr[p] = op[0];
            if (op != 2'h2 && a[4:0] == 5'h04) e_led[p] = op[0];
            if (op != 2'h2 && p == 0 && a[4:3] == 2'h2) e_acu[a[2:0]] = op[0];
        end
        i_host.bit_op(a, op);
        @(negedge mclk_in);
    endtask : step
    task automatic tally_and_finish();
        $display("errors=%0d checked=%0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : tally_and_finish
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {n_errors, checked} = 0;
        lfsr_q = 32'h754d;
        {dsr, ring, lvl_lo, lvl_hi, ctrl_bit, acu_st} = 28'h0;
        {e_rd, e_dtr, e_led, e_csel, e_acu, e_sel} = 26'h0;
        rst_n_in = 1'b0;
        for (int p = 0; p < 4; p++) begin
            base_sw[6*p +: 6] = {lfsr_q[4*p +: 4], 2'(p)};
        end
        repeat (16) @(negedge mclk_in);
        rst_n_in = 1'b1;
        // every aux code with every single bit op, back to back
        for (int p = 0; p < 4; p++) begin
            for (int c = 0; c < 64; c++) begin
                for (int op = 0; op < 3; op++) begin
                    step({base_sw[6*p +: 6], 6'(c)}, 2'(op));
                end
            end
        end
        // random traffic, half aimed at a port window
        for (int i = 0; i < 3000; i++) begin
            lfsr_q = next_rnd(lfsr_q);
            rnd_a = lfsr_q[11:0];
            if (lfsr_q[14]) rnd_a[11:6] = base_sw[6*lfsr_q[13:12] +: 6];
            step(rnd_a, (lfsr_q[16:15] == 2'h3) ? 2'h2 : lfsr_q[16:15]);
        end
        step(12'h000, 2'h2);
        tally_and_finish();
    end
endmodule : serial_port_bit_address_decoder_test
